/* File: src/hpp_pkg.sv */
// Shared constants and state types for the host parallel port, both ends.
package hpp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 6;
    localparam int NUM_REGS = 256;

    // Channel n control register sits at CHAN_CTRL_BASE + n.
    localparam logic [7:0] CHAN_CTRL_BASE = 8'h00;
    localparam int CTRL_IE_BIT = 0;
    // Sticky per-channel interrupt status, write one to clear.
    localparam logic [7:0] INT_STATUS_ADDR = 8'h08;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // Port clock limit and the host's divider derived from it.
    localparam int PCLK_MAX_MHZ = 66;
    localparam int PCLK_MIN_PERIOD_PS = (1000000 + PCLK_MAX_MHZ - 1) / PCLK_MAX_MHZ;
    localparam int CLK_SYS_PERIOD_PS = 100000;
    localparam int PCLK_HALF_CALC = (PCLK_MIN_PERIOD_PS + 2 * CLK_SYS_PERIOD_PS - 1) / (2 * CLK_SYS_PERIOD_PS);
    localparam int PCLK_HALF_CYC = (PCLK_HALF_CALC < 1) ? 1 : PCLK_HALF_CALC;
    // Address and data stand this long before a strobe, two port clock periods.
    localparam int SETUP_CYC = 4 * PCLK_HALF_CYC;

    typedef enum logic {HPP_DEV_IDLE, HPP_DEV_DONE} hpp_dev_state_t;
    typedef enum logic [1:0] {HPP_HOST_IDLE, HPP_HOST_SETUP, HPP_HOST_STROBE, HPP_HOST_RELEASE} hpp_host_state_t;
endpackage

/* File: src/hpp_if.sv */
// Pin-level interface between the host controller and the port of the line interface device.
`timescale 1ns/100ps
interface hpp_if;
    logic pclk;
    logic host_timing_select;
    logic reg_reset_n;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [7:0] addr;
    logic [7:0] host_d_o;
    logic host_d_oe_n;
    logic [7:0] dev_d_o;
    logic dev_d_oe_n;
    logic [7:0] data;
    logic rdy_o;
    logic rdy_oe_n;
    logic rdy;
    logic int_o;
    logic int_oe_n;
    logic int_n;

    // Undriven lines read high, as the pull-ups would make them.
    assign data = !dev_d_oe_n ? dev_d_o : (!host_d_oe_n ? host_d_o : 8'hFF);
    assign rdy = rdy_oe_n ? 1'b1 : rdy_o;
    assign int_n = int_oe_n ? 1'b1 : int_o;

    modport dev (
        input pclk,
        input host_timing_select,
        input reg_reset_n,
        input cs_n,
        input wr_n,
        input rd_n,
        input addr,
        input data,
        output dev_d_o,
        output dev_d_oe_n,
        output rdy_o,
        output rdy_oe_n,
        output int_o,
        output int_oe_n
    );

    modport host (
        output pclk,
        output host_timing_select,
        output reg_reset_n,
        output cs_n,
        output wr_n,
        output rd_n,
        output addr,
        output host_d_o,
        output host_d_oe_n,
        input data,
        input rdy,
        input int_n
    );
endinterface

/* File: src/hpp_host.sv */
// Host controller end: runs register accesses over the parallel port.
`timescale 1ns/100ps
module hpp_host (
    input wire logic clk_sys,
    input wire logic reset,
    hpp_if.host bus,
    input wire logic sync_mode,
    input wire logic reg_reset_req,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic irq
);
    hpp_pkg::hpp_host_state_t state_q;
    logic [7:0] div_cnt_q;
    logic [7:0] wait_q;
    logic pclk_q;
    logic mode_q;
    logic rrst_n_q;
    logic cs_n_q;
    logic wr_n_q;
    logic rd_n_q;
    logic write_q;
    logic [7:0] addr_q;
    logic [7:0] d_o_q;
    logic d_oe_n_q;
    logic cmd_ready_q;
    logic rsp_valid_q;
    logic [7:0] rsp_rdata_q;
    logic irq_q;
    logic rdy_s1_q;
    logic rdy_s2_q;
    logic int_s1_q;
    logic int_s2_q;
    logic [7:0] dat_s1_q;
    logic [7:0] dat_s2_q;

    assign bus.pclk = pclk_q;
    assign bus.host_timing_select = mode_q;
    assign bus.reg_reset_n = rrst_n_q;
    assign bus.cs_n = cs_n_q;
    assign bus.wr_n = wr_n_q;
    assign bus.rd_n = rd_n_q;
    assign bus.addr = addr_q;
    assign bus.host_d_o = d_o_q;
    assign bus.host_d_oe_n = d_oe_n_q;
    assign cmd_ready = cmd_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign irq = irq_q;

    // Port clock is divided down so it never runs above the port's limit.
    // It turns on the falling edge so that its rising edges sit midway between pin changes.
    // Launching pins and port clock on one edge would leave the device no hold time.
    always_ff @(negedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            div_cnt_q <= 8'h00;
            pclk_q <= 1'b0;
        end
        else if (div_cnt_q == 8'(hpp_pkg::PCLK_HALF_CYC - 1))
        begin
            div_cnt_q <= 8'h00;
            pclk_q <= ~pclk_q; // R2
        end
        else
        begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            mode_q <= 1'b0;
            rrst_n_q <= 1'b0;
        end
        else
        begin
            mode_q <= sync_mode; // R6
            rrst_n_q <= ~reg_reset_req; // R5
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rdy_s1_q <= 1'b1;
            rdy_s2_q <= 1'b1;
            int_s1_q <= 1'b1;
            int_s2_q <= 1'b1;
            dat_s1_q <= 8'h00;
            dat_s2_q <= 8'h00;
            irq_q <= 1'b0;
        end
        else
        begin
            rdy_s1_q <= bus.rdy;
            rdy_s2_q <= rdy_s1_q;
            int_s1_q <= bus.int_n;
            int_s2_q <= int_s1_q;
            dat_s1_q <= bus.data;
            dat_s2_q <= dat_s1_q;
            irq_q <= ~int_s2_q; // R8
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= hpp_pkg::HPP_HOST_IDLE;
            wait_q <= 8'h00;
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            write_q <= 1'b0;
            addr_q <= 8'h00;
            d_o_q <= 8'h00;
            d_oe_n_q <= 1'b1;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                hpp_pkg::HPP_HOST_IDLE:
                begin
                    cmd_ready_q <= 1'b1;
                    if (cmd_valid && cmd_ready_q)
                    begin
                        cmd_ready_q <= 1'b0;
                        cs_n_q <= 1'b0; // R1
                        addr_q <= cmd_addr; // R11
                        write_q <= cmd_write;
                        d_o_q <= cmd_wdata;
                        d_oe_n_q <= ~cmd_write; // R12
                        wait_q <= 8'(hpp_pkg::SETUP_CYC);
                        state_q <= hpp_pkg::HPP_HOST_SETUP;
                    end
                end
                hpp_pkg::HPP_HOST_SETUP:
                begin
                    if (wait_q == 8'h00)
                    begin
                        wr_n_q <= ~write_q; // R3
                        rd_n_q <= write_q; // R4
                        state_q <= hpp_pkg::HPP_HOST_STROBE;
                    end
                    else
                    begin
                        wait_q <= wait_q - 8'h01;
                    end
                end
                hpp_pkg::HPP_HOST_STROBE:
                begin
                    if (!rdy_s2_q)
                    begin
                        rsp_rdata_q <= write_q ? 8'h00 : dat_s2_q;
                        wr_n_q <= 1'b1;
                        rd_n_q <= 1'b1;
                        state_q <= hpp_pkg::HPP_HOST_RELEASE;
                    end
                end
                default:
                begin
                    if (rdy_s2_q)
                    begin
                        cs_n_q <= 1'b1;
                        d_oe_n_q <= 1'b1;
                        rsp_valid_q <= 1'b1;
                        state_q <= hpp_pkg::HPP_HOST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

/* File: src/hpp_dev.sv */
// Device end of the host parallel port: register file, access handling and interrupt pin.
`timescale 1ns/100ps
// Function
// R1 - Strobes ignored while select is high.
// R2 - Host port clock never above 66 MHz.
// R3 - Write strobe low latches data into register.
// R4 - Read strobe low drives register onto bus.
// R5 - Register reset low restores all defaults. A channel event in the same cycle still sets its status bit.
// R6 - Timing select high: port follows port clock.
// R7 - Timing select low: internal clock, asynchronous.
// R8 - New interrupt drives interrupt pin low.
// R9 - Cleared enable bit suppresses interrupt pin.
// R10 - Interrupt stays low until host services it.
// R11 - All eight address bits are decoded.
// R12 - Data bus driven only during reads.
// R13 - Ready acknowledge marks access completion.
// R14 - Interrupt pin is open drain.
module hpp_dev (
    input wire logic clk_sys,
    input wire logic reset,
    hpp_if.dev bus,
    input wire logic [hpp_pkg::NUM_CH-1:0] ch_event,
    output logic [hpp_pkg::NUM_CH-1:0][7:0] chan_ctrl
);
    hpp_pkg::hpp_dev_state_t state_q;
    logic [7:0] regs_q [hpp_pkg::NUM_REGS];
    logic [hpp_pkg::NUM_CH-1:0] int_stat_q;
    logic [hpp_pkg::NUM_CH-1:0] ie_vec;

    // Port clock domain, used only in synchronous mode.
    logic p_cs_n_q, p_wr_n_q, p_rd_n_q;
    logic [7:0] p_addr_in_q;
    logic [7:0] p_d_in_q;
    logic p_prev_q;
    logic p_write_q;
    logic [7:0] p_addr_q;
    logic [7:0] p_wdat_q;
    logic p_req_tgl_q;
    logic p_strobe;

    // Internal clock domain.
    logic [2:0] pin_s1_q, pin_s2_q;
    logic [7:0] addr_s1_q, addr_s2_q;
    logic [7:0] wdat_s1_q, wdat_s2_q;
    logic mode_s1_q, mode_s2_q;
    logic rrst_s1_q, rrst_s2_q;
    logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic drive_lo_q;
    logic ack_oe_n_q;
    logic [7:0] dout_q;
    logic dout_oe_n_q;
    logic int_oe_n_q;

    logic a_strobe;
    logic start;
    logic acc_write;
    logic [7:0] acc_addr;
    logic [7:0] acc_wdat;
    logic [7:0] rd_val;
    logic irq_d;

    assign bus.dev_d_o = dout_q;
    assign bus.dev_d_oe_n = dout_oe_n_q;
    assign bus.rdy_o = drive_lo_q;
    assign bus.rdy_oe_n = ack_oe_n_q;
    assign bus.int_o = drive_lo_q;
    assign bus.int_oe_n = int_oe_n_q;

    assign p_strobe = ~p_cs_n_q & (~p_wr_n_q | ~p_rd_n_q); // R1

    // The host moves its pins half a system clock away from any rising port clock edge, so one capture stage suffices.
    // The request fields stay frozen until the next strobe, long after the toggle has crossed.
    always_ff @(posedge bus.pclk or posedge reset)
    begin
        if (reset)
        begin
            p_cs_n_q <= 1'b1;
            p_wr_n_q <= 1'b1;
            p_rd_n_q <= 1'b1;
            p_addr_in_q <= 8'h00;
            p_d_in_q <= 8'h00;
            p_prev_q <= 1'b0;
            p_write_q <= 1'b0;
            p_addr_q <= 8'h00;
            p_wdat_q <= 8'h00;
            p_req_tgl_q <= 1'b0;
        end
        else
        begin
            p_cs_n_q <= bus.cs_n;
            p_wr_n_q <= bus.wr_n;
            p_rd_n_q <= bus.rd_n;
            p_addr_in_q <= bus.addr;
            p_d_in_q <= bus.data;
            p_prev_q <= p_strobe;
            if (p_strobe && !p_prev_q)
            begin
                p_write_q <= ~p_wr_n_q;
                p_addr_q <= p_addr_in_q;
                p_wdat_q <= p_d_in_q;
                p_req_tgl_q <= ~p_req_tgl_q; // R6
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
            addr_s1_q <= 8'h00;
            addr_s2_q <= 8'h00;
            wdat_s1_q <= 8'h00;
            wdat_s2_q <= 8'h00;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            rrst_s1_q <= 1'b1;
            rrst_s2_q <= 1'b1;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= {bus.cs_n, bus.wr_n, bus.rd_n};
            pin_s2_q <= pin_s1_q;
            addr_s1_q <= bus.addr;
            addr_s2_q <= addr_s1_q;
            wdat_s1_q <= bus.data;
            wdat_s2_q <= wdat_s1_q;
            mode_s1_q <= bus.host_timing_select;
            mode_s2_q <= mode_s1_q;
            rrst_s1_q <= bus.reg_reset_n;
            rrst_s2_q <= rrst_s1_q;
            tgl_s1_q <= p_req_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    assign a_strobe = ~pin_s2_q[2] & (~pin_s2_q[1] | ~pin_s2_q[0]); // R1

    // Mode picks the request source; the internal clock always runs the register file.
    always_comb
    begin
        if (mode_s2_q)
        begin
            start = tgl_s2_q ^ tgl_s3_q; // R6
            acc_write = p_write_q;
            acc_addr = p_addr_q;
            acc_wdat = p_wdat_q;
        end
        else
        begin
            start = a_strobe; // R7
            acc_write = ~pin_s2_q[1];
            acc_addr = addr_s2_q;
            acc_wdat = wdat_s2_q;
        end
    end

    assign rd_val = (acc_addr == hpp_pkg::INT_STATUS_ADDR) ? 8'(int_stat_q) : regs_q[acc_addr]; // R11

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < hpp_pkg::NUM_REGS; i++)
            begin
                regs_q[i] <= hpp_pkg::REG_RESET_VAL;
            end
        end
        else if (!rrst_s2_q)
        begin
            for (int i = 0; i < hpp_pkg::NUM_REGS; i++)
            begin
                regs_q[i] <= hpp_pkg::REG_RESET_VAL; // R5
            end
        end
        else if (state_q == hpp_pkg::HPP_DEV_IDLE && start && acc_write
                 && acc_addr != hpp_pkg::INT_STATUS_ADDR)
        begin
            regs_q[acc_addr] <= acc_wdat; // R3
        end
    end

    // An event in the same cycle as its clear keeps the bit set.
    for (genvar ch = 0; ch < hpp_pkg::NUM_CH; ch++)
    begin : g_ch
        assign ie_vec[ch] = regs_q[hpp_pkg::CHAN_CTRL_BASE + 8'(ch)][hpp_pkg::CTRL_IE_BIT];
        assign chan_ctrl[ch] = regs_q[hpp_pkg::CHAN_CTRL_BASE + 8'(ch)];

        always_ff @(posedge clk_sys or posedge reset)
        begin
            if (reset)
            begin
                int_stat_q[ch] <= 1'b0;
            end
            else if (ch_event[ch])
            begin
                int_stat_q[ch] <= 1'b1;
            end
            else if (!rrst_s2_q)
            begin
                int_stat_q[ch] <= 1'b0;
            end
            else if (state_q == hpp_pkg::HPP_DEV_IDLE && start && acc_write
                     && acc_addr == hpp_pkg::INT_STATUS_ADDR && acc_wdat[ch])
            begin
                int_stat_q[ch] <= 1'b0; // R10
            end
        end
    end

    assign irq_d = |(int_stat_q & ie_vec); // R9

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            int_oe_n_q <= 1'b1;
            drive_lo_q <= 1'b0;
        end
        else
        begin
            int_oe_n_q <= ~irq_d; // R8
            drive_lo_q <= 1'b0; // R14
        end
    end

    // Acknowledge and read data stand until the host lifts its strobe.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= hpp_pkg::HPP_DEV_IDLE;
            ack_oe_n_q <= 1'b1;
            dout_q <= 8'h00;
            dout_oe_n_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                hpp_pkg::HPP_DEV_IDLE:
                begin
                    if (start)
                    begin
                        ack_oe_n_q <= 1'b0; // R13
                        if (!acc_write)
                        begin
                            dout_q <= rd_val; // R4
                            dout_oe_n_q <= 1'b0; // R12
                        end
                        state_q <= hpp_pkg::HPP_DEV_DONE;
                    end
                end
                default:
                begin
                    if (!a_strobe)
                    begin
                        ack_oe_n_q <= 1'b1;
                        dout_oe_n_q <= 1'b1; // R12
                        state_q <= hpp_pkg::HPP_DEV_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

/* File: test/hpp_checker.sv */
// Concurrent checks on the pins between the host and device ends of the parallel port.
`timescale 1ns/100ps
module hpp_checker (
    input logic clk_sys,
    input logic reset,
    input logic reg_reset_n,
    input logic cs_n,
    input logic wr_n,
    input logic rd_n,
    input logic [7:0] addr,
    input logic [7:0] data,
    input logic dev_d_oe_n,
    input logic rdy_oe_n,
    input logic rdy,
    input logic int_oe_n,
    input logic int_n
);
    logic [4:0] since_q;

    // Counts cycles since the host last could have serviced an interrupt, saturating.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            since_q <= 5'h1F;
        else if ((!cs_n && !wr_n) || !reg_reset_n)
            since_q <= 5'h00;
        else if (since_q != 5'h1F)
            since_q <= since_q + 5'h01;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    select_gate_a: assert property (cs_n |-> dev_d_oe_n && rdy_oe_n)
        else $error("device drives a pin while deselected");
    ack_source_a: assert property ($fell(rdy_oe_n) |-> !cs_n && !(rd_n && wr_n))
        else $error("acknowledge without a selected strobe");
    ack_bound_a: assert property ($fell(rd_n && wr_n) && !cs_n |-> ##[1:12] !rdy)
        else $error("no acknowledge after a strobe");
    ack_hold_a: assert property ($rose(rdy) |-> $past(rd_n && wr_n))
        else $error("acknowledge released while strobe low");
    read_drive_a: assert property ($fell(dev_d_oe_n) |-> !rd_n && !cs_n)
        else $error("data bus driven outside a read");
    write_quiet_a: assert property (!wr_n |-> dev_d_oe_n)
        else $error("device drives data during a write");
    read_stable_a: assert property (!dev_d_oe_n && $past(!dev_d_oe_n) |-> $stable(data))
        else $error("read data changed while driven");
    addr_steady_a: assert property (!cs_n && !(rd_n && wr_n) |-> $stable(addr))
        else $error("address moved during a strobe");
    int_service_a: assert property ($rose(int_n) |-> since_q < 5'h08)
        else $error("interrupt released without service");
    int_drain_a: assert property (int_n == int_oe_n)
        else $error("interrupt pin not open drain");
    reg_reset_quiet_a: assert property (!reg_reset_n [*5] |=> int_n)
        else $error("interrupt held through register reset");
endmodule

/* File: test/tb.sv */
// Self-checking bench joining the host and device ends of the parallel port.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sync_mode = 1'b0;
    logic reg_reset_req = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [5:0] ch_event = 6'h00;
    logic cmd_ready;
    logic rsp_valid;
    logic irq;
    logic [7:0] rsp_rdata;
    logic [5:0][7:0] chan_ctrl;
    logic [7:0] mdl [256];
    logic [7:0] exp_q [$];
    logic [7:0] exp_v;
    logic [7:0] a;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'h05f7;

    hpp_if bus_if ();
    hpp_host u_hpp_host (.clk_sys(clk_sys), .reset(reset), .bus(bus_if.host), .sync_mode(sync_mode),
        .reg_reset_req(reg_reset_req), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq(irq));
    hpp_dev u_hpp_dev (.clk_sys(clk_sys), .reset(reset), .bus(bus_if.dev), .ch_event(ch_event),
        .chan_ctrl(chan_ctrl));
    hpp_checker u_hpp_checker (.clk_sys(clk_sys), .reset(reset), .reg_reset_n(bus_if.reg_reset_n),
        .cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .addr(bus_if.addr), .data(bus_if.data),
        .dev_d_oe_n(bus_if.dev_d_oe_n), .rdy_oe_n(bus_if.rdy_oe_n), .rdy(bus_if.rdy),
        .int_oe_n(bus_if.int_oe_n), .int_n(bus_if.int_n));

    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Status at 0x08 is modelled as sticky bits cleared by writing ones; other places store the byte.
    task automatic access(input logic wr, input logic [7:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 500)
        begin
            wait_cyc(1);
            n++;
        end
        if (n >= 500)
        begin
            error_cnt++;
            finish_test();
        end
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = ad;
        cmd_wdata = d;
        exp_q.push_back(wr ? 8'h00 : mdl[ad]);
        if (wr && ad == hpp_pkg::INT_STATUS_ADDR)
            mdl[ad] = mdl[ad] & ~d;
        else if (wr)
            mdl[ad] = d;
        wait_cyc(1);
        cmd_valid = 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((exp_q.size() > 0 || cmd_ready !== 1'b1) && n < 2000)
        begin
            wait_cyc(1);
            n++;
        end
        if (n >= 2000)
        begin
            error_cnt++;
            finish_test();
        end
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 50)
        begin
            wait_cyc(1);
            n++;
        end
        if (n >= 50)
        begin
            error_cnt++;
            finish_test();
        end
    endtask

    task automatic raise_event(input int ch);
        ch_event[ch] = 1'b1;
        mdl[hpp_pkg::INT_STATUS_ADDR][ch] = 1'b1;
        wait_cyc(1);
        ch_event[ch] = 1'b0;
    endtask

    // Sampled on the falling edge so the response flops have settled.
    always @(negedge clk_sys)
    begin
        if (rsp_valid === 1'b1)
        begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK(rsp_rdata, exp_v)
        end
    end

    initial
    begin
        for (int i = 0; i < 256; i++)
            mdl[i] = hpp_pkg::REG_RESET_VAL;
        wait_cyc(10);
        reset = 1'b0;
        wait_cyc(2);
        for (int i = 0; i < 256; i++)
            access(1'b0, i[7:0], 8'h00);
        for (int i = 0; i < 256; i++)
            if (i != 8)
                access(1'b1, i[7:0], 8'($random(seed)));
        for (int i = 0; i < 256; i++)
            access(1'b0, i[7:0], 8'h00);
        drain();
        for (int i = 0; i < 6; i++)
            `CHK(chan_ctrl[i], mdl[i])
        sync_mode = 1'b1;
        wait_cyc(3);
        for (int i = 0; i < 12; i++)
        begin
            a = 8'($random(seed));
            a = (a == hpp_pkg::INT_STATUS_ADDR) ? 8'h09 : a;
            access(1'b1, a, 8'($random(seed)));
            access(1'b0, a, 8'h00);
        end
        drain();
        sync_mode = 1'b0;
        wait_cyc(3);
        for (int i = 0; i < 6; i++)
            access(1'b1, i[7:0], 8'h00);
        access(1'b1, 8'h02, 8'h01);
        drain();
        raise_event(2);
        wait_irq(1'b1);
        `CHK(irq, 1'b1)
        wait_cyc(40);
        `CHK(irq, 1'b1)
        access(1'b0, hpp_pkg::INT_STATUS_ADDR, 8'h00);
        access(1'b1, hpp_pkg::INT_STATUS_ADDR, 8'h04);
        drain();
        wait_irq(1'b0);
        `CHK(irq, 1'b0)
        raise_event(3);
        wait_cyc(10);
        `CHK(irq, 1'b0)
        access(1'b1, 8'h03, 8'h01);
        drain();
        wait_irq(1'b1);
        `CHK(irq, 1'b1)
        access(1'b1, 8'h03, 8'h00);
        drain();
        wait_irq(1'b0);
        `CHK(irq, 1'b0)
        access(1'b1, 8'h03, 8'h81);
        drain();
        wait_irq(1'b1);
        reg_reset_req = 1'b1;
        wait_cyc(10);
        reg_reset_req = 1'b0;
        wait_cyc(6);
        `CHK(irq, 1'b0)
        for (int i = 0; i < 256; i++)
            mdl[i] = hpp_pkg::REG_RESET_VAL;
        for (int i = 0; i < 6; i++)
            `CHK(chan_ctrl[i], hpp_pkg::REG_RESET_VAL)
        for (int i = 0; i < 16; i++)
            access(1'b0, i[7:0], 8'h00);
        drain();
        finish_test();
    end
endmodule
